// *** cisc_params.svh ***
// Purpose: Constants of the crypto interrupt and control-status block.
// Assumes: Register bits are numbered with bit 0 as the most significant bit.
// Notes:   Included by both ends; definitions only.
`ifndef CISC_PARAMS_SVH
`define CISC_PARAMS_SVH

// Host bus geometry.
`define CISC_ADDR_W        12
`define CISC_DATA_W        32
`define CISC_NUM_EU        5

// Register offsets (word addresses on the host bus).
`define CISC_OFS_CONTROL_AND_STATUS     12'h900
`define CISC_OFS_ID        12'h901
`define CISC_OFS_INTERRUPT_MASK_REG     12'h902
`define CISC_OFS_EU_LIMIT  12'h900

// Field positions inside the control-status register.
`define CISC_CS_MASKED_LSB 11
`define CISC_CS_RAW_LSB    18
`define CISC_CS_PEND_BIT   23
`define CISC_CS_DEST_LSB   24
`define CISC_CS_AU_LSB     28
`define CISC_CS_RST_BIT    31

// Field position inside the mask register.
`define CISC_IM_LSB        27

// Field values.
`define CISC_AU_OFF        3'h0
`define CISC_AU_ON         3'h1
`define CISC_DEST_NONE     4'h0
`define CISC_DEST_BASE     4'h8

// Reset values.
`define CISC_MASK_RST      5'h1f
`define CISC_DEST_RST      4'h0
`define CISC_AU_RST        3'h0

// Version fields of the identification register; values are arbitrary.
`define CISC_VER_DEVICE    3'h1
`define CISC_VER_DIGEST    3'h1
`define CISC_VER_DES       3'h1
`define CISC_VER_ARC4      3'h1
`define CISC_VER_RANDOM    3'h1
`define CISC_VER_BUSCTL    3'h1
`define CISC_VER_PKEY      3'h1

`endif

// *** cisc_pkg.sv ***
// Purpose: Types shared by the two ends of the control-status link.
// Assumes: cisc_params.svh supplies the widths.
// Notes:   Unit index 0..4 is des, arc four, digest, random, public key.
`include "cisc_params.svh"
package cisc_pkg;
	typedef logic [0:`CISC_NUM_EU-1]  cisc_eu_vec_t;
	typedef logic [0:`CISC_DATA_W-1]  cisc_word_t;
	typedef logic [`CISC_ADDR_W-1:0]  cisc_addr_t;
endpackage

// *** cisc_if.sv ***
// Purpose: Host bus between the coprocessor and the host processor.
// Assumes: One clock; all signals synchronous to it.
// Notes:   Data buses are split per direction, so no pin is two-way.
`timescale 1ns/100ps
`default_nettype none
interface cisc_if;
	import cisc_pkg::*;
	logic       bus_cs_n;
	logic       bus_we;
	cisc_addr_t bus_addr;
	cisc_word_t bus_wdata;
	cisc_word_t bus_rdata;
	logic       bus_ack;
	logic       irq_n;
	modport dev  (input bus_cs_n, bus_we, bus_addr, bus_wdata, output bus_rdata, bus_ack, irq_n);
	modport host (output bus_cs_n, bus_we, bus_addr, bus_wdata, input bus_rdata, bus_ack, irq_n);
endinterface
`default_nettype wire

// *** cisc_dev.sv ***
// Purpose: Interrupt gathering and control-status registers of the coprocessor.
// Assumes: Unit interrupts are levels held until serviced; done is a pulse.
// Notes:   Bit 0 of every register is the most significant data bit.
// Contract
// - Status bits 20-22 show digest, random, public-key raw.
// - Status bit 23 shows any interrupt pending.
// - Destination bits 24-27 choose the one active unit.
// - Host finishes operation before rewriting destination.
// - Auto-unmask field 000 off, 001 on.
// - Auto-unmask clears active unit mask on completion.
// - Host masks unit first, then enables auto-unmask.
// - Status bit 31 resets device, then self-clears.
// - Busy unit refuses host access; registers stay open.
// - Read-only identification word at 0x901, fixed value.
// - Identification holds 3-bit version fields, rest zero.
// - All unit interrupts combine into one masked line.
// - Interrupt line holds until all pending serviced.
// - All unit interrupts have equal priority.
// - Mask bits 27-31: des..public key, 1 masks.
// - Host writes zeros to reserved bits.
// - Status bits 18-22 show raw unit interrupts.
// - Status bits 11-15 show masked unit interrupts.
`timescale 1ns/100ps
`default_nettype none
`include "cisc_params.svh"
module cisc_dev
	import cisc_pkg::*;
(
	// Clock and reset.
	input  wire logic   ref_clk_in,
	input  wire logic   rstn_in,
	// Host bus.
	cisc_if.dev         bus,
	// Execution units.
	input  wire logic   [0:`CISC_NUM_EU-1] eu_irq_in,
	input  wire logic   [0:`CISC_NUM_EU-1] eu_done_in,
	input  wire logic   eu_busy_in,
	output logic        eu_req_out,
	output logic        eu_we_out,
	output cisc_addr_t  eu_addr_out,
	output cisc_word_t  eu_wdata_out,
	input  wire cisc_word_t eu_rdata_in,
	// Control towards the rest of the device.
	output logic        [3:0] dest_out,
	output logic        dev_reset_out
);

	typedef struct packed {
		cisc_eu_vec_t raw;
		cisc_eu_vec_t mask;
		logic [3:0]   dest;
		logic [2:0]   au;
		logic         rst;
		logic         irq_n;
		logic         ack;
		cisc_word_t   rdata;
		logic         eu_req;
		logic         eu_we;
		cisc_addr_t   eu_addr;
		cisc_word_t   eu_wdata;
		logic         eu_rd_pend;
	} cisc_dev_st_t;

	localparam cisc_dev_st_t ST_RST = '{
		raw: '0, mask: `CISC_MASK_RST, dest: `CISC_DEST_RST, au: `CISC_AU_RST,
		rst: 1'b0, irq_n: 1'b1, ack: 1'b0, rdata: '0, eu_req: 1'b0, eu_we: 1'b0,
		eu_addr: '0, eu_wdata: '0, eu_rd_pend: 1'b0
	};

	cisc_dev_st_t st_r;
	cisc_dev_st_t st_nxt;

	// Identification word is a constant built from the version fields.
	function automatic cisc_word_t id_word();
		cisc_word_t w;
		w        = '0;
		w[8:10]  = `CISC_VER_DEVICE;
		w[11:13] = `CISC_VER_DIGEST;
		w[14:16] = `CISC_VER_DES;
		w[17:19] = `CISC_VER_ARC4;
		w[20:22] = `CISC_VER_RANDOM;
		w[26:28] = `CISC_VER_BUSCTL;
		w[29:31] = `CISC_VER_PKEY;
		return w;
	endfunction

	// Status word; all units share one plain OR with no ordering among them.
	function automatic cisc_word_t control_and_status_word(cisc_dev_st_t s);
		cisc_word_t   w;
		cisc_eu_vec_t m;
		w = '0;
		m = s.raw & ~s.mask;
		w[`CISC_CS_MASKED_LSB +: `CISC_NUM_EU] = m;
		w[`CISC_CS_RAW_LSB +: `CISC_NUM_EU]    = s.raw;
		w[`CISC_CS_PEND_BIT]                   = |s.raw;
		w[`CISC_CS_DEST_LSB +: 4]              = s.dest;
		w[`CISC_CS_AU_LSB +: 3]                = s.au;
		w[`CISC_CS_RST_BIT]                    = s.rst;
		return w;
	endfunction

	// Next-state logic for the whole block.
	always_comb begin
		logic [2:0]   idx;
		logic         dest_ok;
		cisc_eu_vec_t masked;
		st_nxt         = st_r;
		idx            = st_r.dest[2:0];
		dest_ok        = st_r.dest[3] && (idx < 3'(`CISC_NUM_EU));
		masked         = '0;
		st_nxt.ack     = 1'b0;
		st_nxt.eu_req  = 1'b0;
		st_nxt.raw     = eu_irq_in;
		// An EU read answers one cycle late with the unit's data.
		if (st_r.eu_rd_pend) begin
			st_nxt.rdata      = eu_rdata_in;
			st_nxt.ack        = 1'b1;
			st_nxt.eu_rd_pend = 1'b0;
		end
		// Host access; a refused EU access still acks so the host never hangs.
		if (!bus.bus_cs_n && !st_r.ack && !st_r.eu_rd_pend) begin
			st_nxt.ack   = 1'b1;
			st_nxt.rdata = '0;
			if (bus.bus_addr < `CISC_OFS_EU_LIMIT) begin
				if (!eu_busy_in) begin
					st_nxt.eu_req   = 1'b1;
					st_nxt.eu_we    = bus.bus_we;
					st_nxt.eu_addr  = bus.bus_addr;
					st_nxt.eu_wdata = bus.bus_wdata;
					if (!bus.bus_we) begin
						st_nxt.ack        = 1'b0;
						st_nxt.eu_rd_pend = 1'b1;
					end
				end
			end else if (bus.bus_we) begin
				unique case (bus.bus_addr)
					`CISC_OFS_CONTROL_AND_STATUS: begin
						st_nxt.dest = bus.bus_wdata[`CISC_CS_DEST_LSB +: 4];
						st_nxt.au   = bus.bus_wdata[`CISC_CS_AU_LSB +: 3];
						st_nxt.rst  = bus.bus_wdata[`CISC_CS_RST_BIT];
					end
					`CISC_OFS_INTERRUPT_MASK_REG: begin
						st_nxt.mask = bus.bus_wdata[`CISC_IM_LSB +: `CISC_NUM_EU];
					end
					default: begin
						// The identification word and unused offsets ignore writes.
					end
				endcase
			end else begin
				unique case (bus.bus_addr)
					`CISC_OFS_CONTROL_AND_STATUS: st_nxt.rdata = control_and_status_word(st_r);
					`CISC_OFS_ID:    st_nxt.rdata = id_word();
					`CISC_OFS_INTERRUPT_MASK_REG: begin
						st_nxt.rdata = '0;
						st_nxt.rdata[`CISC_IM_LSB +: `CISC_NUM_EU] = st_r.mask;
					end
					default:         st_nxt.rdata = '0;
				endcase
			end
		end
		// Completion of the active unit opens its mask; it wins over a mask write.
		if ((st_r.au == `CISC_AU_ON) && dest_ok && eu_done_in[idx]) begin
			st_nxt.mask[idx] = 1'b0;
		end
		// Line stays low while any unmasked source is still high.
		masked       = st_nxt.raw & ~st_nxt.mask;
		st_nxt.irq_n = ~(|masked);
		// Software reset: bit stands one cycle, then the whole block reloads.
		if (st_r.rst) begin
			st_nxt = ST_RST;
		end
	end

	// State register.
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			st_r <= ST_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs straight from the state register.
	assign bus.bus_rdata  = st_r.rdata;
	assign bus.bus_ack    = st_r.ack;
	assign bus.irq_n      = st_r.irq_n;
	assign eu_req_out     = st_r.eu_req;
	assign eu_we_out      = st_r.eu_we;
	assign eu_addr_out    = st_r.eu_addr;
	assign eu_wdata_out   = st_r.eu_wdata;
	assign dest_out       = st_r.dest;
	assign dev_reset_out  = st_r.rst;   // High the cycle before the reload.

endmodule
`default_nettype wire

// *** cisc_host.sv ***
// Purpose: Host-side master for the coprocessor control-status link.
// Assumes: One access at a time; the device acks every access.
// Notes:   Start command runs mask-then-enable so only the final interrupt shows.
`timescale 1ns/100ps
`default_nettype none
`include "cisc_params.svh"
module cisc_host
	import cisc_pkg::*;
(
	// Clock and reset.
	input  wire logic   ref_clk_in,
	input  wire logic   rstn_in,
	// Host bus.
	cisc_if.host        bus,
	// Plain access command.
	input  wire logic   cmd_valid_in,
	input  wire logic   cmd_we_in,
	input  wire cisc_addr_t cmd_addr_in,
	input  wire cisc_word_t cmd_wdata_in,
	output logic        cmd_ready_out,
	output logic        rsp_valid_out,
	output cisc_word_t  rsp_data_out,
	// Guarded start of one unit with auto-unmask.
	input  wire logic   start_valid_in,
	input  wire logic   [2:0] start_unit_in,
	input  wire logic   op_active_in,
	// Interrupt seen by host software.
	output logic        irq_out
);

	typedef enum logic [1:0] {
		HS_IDLE  = 2'b00,
		HS_WAIT  = 2'b01,
		HS_MASK  = 2'b10,
		HS_START = 2'b11
	} cisc_hstate_t;

	typedef struct packed {
		cisc_hstate_t state;
		logic         cs_n;
		logic         we;
		cisc_addr_t   addr;
		cisc_word_t   wdata;
		logic         rsp;
		cisc_word_t   rdata;
		cisc_eu_vec_t mask;
		logic [2:0]   unit;
		logic         irq;
	} cisc_host_st_t;

	cisc_host_st_t st_r;
	cisc_host_st_t st_nxt;

	// Clean a write so reserved bits go out as zero.
	function automatic cisc_word_t clean_wr(cisc_addr_t a, cisc_word_t d);
		cisc_word_t w;
		w = '0;
		if (a == `CISC_OFS_CONTROL_AND_STATUS) begin
			w[`CISC_CS_DEST_LSB:`CISC_DATA_W-1] = d[`CISC_CS_DEST_LSB:`CISC_DATA_W-1];
		end else if (a == `CISC_OFS_INTERRUPT_MASK_REG) begin
			w[`CISC_IM_LSB:`CISC_DATA_W-1] = d[`CISC_IM_LSB:`CISC_DATA_W-1];
		end else begin
			w = d;
		end
		return w;
	endfunction

	// A control-status write is held back while an operation is running.
	logic cs_blocked;
	logic start_go;
	assign cs_blocked = cmd_we_in && (cmd_addr_in == `CISC_OFS_CONTROL_AND_STATUS) && op_active_in;
	// A start taken on this edge wins, so the plain command must not see ready then.
	assign start_go = (st_r.state == HS_IDLE) && start_valid_in && !op_active_in &&
		(start_unit_in < 3'(`CISC_NUM_EU));
	assign cmd_ready_out = (st_r.state == HS_IDLE) && !cs_blocked && !start_go;

	// Next-state logic.
	always_comb begin
		st_nxt     = st_r;
		st_nxt.rsp = 1'b0;
		st_nxt.irq = ~bus.irq_n;
		unique case (st_r.state)
			HS_IDLE: begin
				st_nxt.cs_n = 1'b1;
				if (start_valid_in && !op_active_in && (start_unit_in < 3'(`CISC_NUM_EU))) begin
					// Mask the unit first so intermediate interrupts stay hidden.
					st_nxt.unit              = start_unit_in;
					st_nxt.mask[start_unit_in] = 1'b1;
					st_nxt.cs_n              = 1'b0;
					st_nxt.we                = 1'b1;
					st_nxt.addr              = `CISC_OFS_INTERRUPT_MASK_REG;
					st_nxt.wdata             = '0;
					st_nxt.wdata[`CISC_IM_LSB +: `CISC_NUM_EU] = st_nxt.mask;
					st_nxt.state             = HS_MASK;
				end else if (cmd_valid_in && !cs_blocked) begin
					st_nxt.cs_n  = 1'b0;
					st_nxt.we    = cmd_we_in;
					st_nxt.addr  = cmd_addr_in;
					st_nxt.wdata = clean_wr(cmd_addr_in, cmd_wdata_in);
					if (cmd_we_in && (cmd_addr_in == `CISC_OFS_INTERRUPT_MASK_REG)) begin
						st_nxt.mask = cmd_wdata_in[`CISC_IM_LSB +: `CISC_NUM_EU];
					end
					st_nxt.state = HS_WAIT;
				end
			end
			HS_WAIT: begin
				st_nxt.cs_n = 1'b1;
				if (bus.bus_ack) begin
					st_nxt.rsp   = 1'b1;
					st_nxt.rdata = bus.bus_rdata;
					st_nxt.state = HS_IDLE;
				end
			end
			HS_MASK: begin
				st_nxt.cs_n = 1'b1;
				if (bus.bus_ack) begin
					// Then select the unit and switch auto-unmask on.
					st_nxt.cs_n  = 1'b0;
					st_nxt.addr  = `CISC_OFS_CONTROL_AND_STATUS;
					st_nxt.wdata = '0;
					st_nxt.wdata[`CISC_CS_DEST_LSB +: 4] = `CISC_DEST_BASE | {1'b0, st_r.unit};
					st_nxt.wdata[`CISC_CS_AU_LSB +: 3]   = `CISC_AU_ON;
					st_nxt.state = HS_START;
				end
			end
			HS_START: begin
				st_nxt.cs_n = 1'b1;
				if (bus.bus_ack) begin
					st_nxt.mask[st_r.unit] = 1'b0;  // Device will open it at completion.
					st_nxt.rsp   = 1'b1;
					st_nxt.rdata = '0;
					st_nxt.state = HS_IDLE;
				end
			end
		endcase
	end

	// State register.
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			st_r <= '{state: HS_IDLE, cs_n: 1'b1, we: 1'b0, addr: '0, wdata: '0, rsp: 1'b0,
				rdata: '0, mask: `CISC_MASK_RST, unit: 3'h0, irq: 1'b0};
		end else begin
			st_r <= st_nxt;
		end
	end

	// Bus and user outputs from flip-flops.
	assign bus.bus_cs_n  = st_r.cs_n;
	assign bus.bus_we    = st_r.we;
	assign bus.bus_addr  = st_r.addr;
	assign bus.bus_wdata = st_r.wdata;
	assign rsp_valid_out = st_r.rsp;
	assign rsp_data_out  = st_r.rdata;
	assign irq_out       = st_r.irq;

endmodule
`default_nettype wire

// *** cisc_props.sv ***
// Purpose: Assertions on the host bus between the two ends of the control-status link.
// Assumes: All signals are sampled on the rising clock edge.
// Notes:   Bit 0 of a bus word is its most significant bit.
`timescale 1ns/100ps
`default_nettype none
`include "cisc_params.svh"
module cisc_props
	import cisc_pkg::*;
(
	// Clock and reset.
	input  wire logic       ref_clk_in,
	input  wire logic       rstn_in,
	// Host bus.
	input  wire logic       bus_cs_n,
	input  wire logic       bus_we,
	input  wire cisc_addr_t bus_addr,
	input  wire cisc_word_t bus_wdata,
	input  wire cisc_word_t bus_rdata,
	input  wire logic       bus_ack,
	input  wire logic       irq_n
);
	// Fixed identification word; reserved fields stay at zero.
	localparam cisc_word_t ID_W = {8'h00, `CISC_VER_DEVICE, `CISC_VER_DIGEST, `CISC_VER_DES, `CISC_VER_ARC4,
		`CISC_VER_RANDOM, 3'h0, `CISC_VER_BUSCTL, `CISC_VER_PKEY};

	// Read strobes of the three registers.
	wire logic rd_cs = !bus_cs_n && !bus_we && bus_addr == `CISC_OFS_CONTROL_AND_STATUS;
	wire logic rd_id = !bus_cs_n && !bus_we && bus_addr == `CISC_OFS_ID;
	wire logic rd_im = !bus_cs_n && !bus_we && bus_addr == `CISC_OFS_INTERRUPT_MASK_REG;

	// Everything below belongs to the one clock domain.
	default clocking dcb @(posedge ref_clk_in);
	endclocking
	default disable iff (!rstn_in);

	AST_REG_ACK: assert property (!bus_cs_n && bus_addr >= `CISC_OFS_CONTROL_AND_STATUS |=> bus_ack)
		else $error("register access not answered next cycle");
	AST_ACK_ONE: assert property (bus_ack |=> !bus_ack)
		else $error("acknowledge longer than one cycle");
	AST_CS_ONE: assert property (!bus_cs_n |=> bus_cs_n)
		else $error("select held longer than one cycle");
	AST_ID_READ: assert property (rd_id |=> bus_ack && bus_rdata == ID_W)
		else $error("identification word wrong");
	AST_IM_RSVD: assert property (rd_im |=> bus_rdata[0:26] == 27'h0)
		else $error("mask reserved bits not zero");
	AST_AU_CODE: assert property (rd_cs |=> bus_rdata[28:30] inside {`CISC_AU_OFF, `CISC_AU_ON})
		else $error("auto field holds an unknown code");
	AST_PEND_ANY: assert property (rd_cs |=> bus_rdata[23] == (bus_rdata[18:22] != 5'h0))
		else $error("pending flag disagrees with raw flags");
	AST_MASKED_SUB: assert property (rd_cs |=> (bus_rdata[11:15] & ~bus_rdata[18:22]) == 5'h0)
		else $error("masked flag without raw flag");
	AST_RST_CLEAR: assert property (rd_cs |=> !bus_rdata[31])
		else $error("software reset bit did not clear");
	AST_IRQ_MATCH: assert property (rd_cs |=> (bus_rdata[11:15] != 5'h0) == !$past(irq_n))
		else $error("interrupt line disagrees with masked flags");
endmodule
`default_nettype wire

// *** crypto_irq_status_control_tb.sv ***
// Purpose: Self-checking bench for the device and host ends joined by one bus.
// Assumes: Stimulus changes 1 ns after the rising edge.
// Notes:   Only the host command and start ports reach the bus; the host never breaks bus rules.
`timescale 1ns/100ps
`default_nettype none
`include "cisc_params.svh"
module crypto_irq_status_control_tb;
	import cisc_pkg::*;
	localparam cisc_word_t ID_W = {8'h00, `CISC_VER_DEVICE, `CISC_VER_DIGEST, `CISC_VER_DES, `CISC_VER_ARC4,
		`CISC_VER_RANDOM, 3'h0, `CISC_VER_BUSCTL, `CISC_VER_PKEY};
	localparam cisc_addr_t CS = `CISC_OFS_CONTROL_AND_STATUS;
	localparam cisc_addr_t IM = `CISC_OFS_INTERRUPT_MASK_REG;
	logic         ref_clk_in = 1'b0;
	logic         rstn_in;
	logic         cmd_valid;
	logic         cmd_we;
	logic         cmd_ready;
	logic         rsp_valid;
	logic         start_valid;
	logic         op_active;
	logic         eu_busy;
	logic         eu_req;
	logic         eu_we;
	logic         fwd_we;
	cisc_addr_t   eu_addr;
	cisc_addr_t   fwd_addr;
	cisc_word_t   eu_wdata;
	cisc_word_t   fwd_wdata;
	logic         dev_reset;
	logic         irq;
	logic [2:0]   start_unit;
	logic [3:0]   dest;
	cisc_addr_t   cmd_addr;
	cisc_word_t   cmd_wdata;
	cisc_word_t   rsp_data;
	cisc_word_t   eu_rdata;
	cisc_word_t   rd;
	cisc_eu_vec_t eu_irq;
	cisc_eu_vec_t eu_done;
	cisc_eu_vec_t r;
	cisc_eu_vec_t m;
	logic [3:0]   dcodes [6] = '{4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'h0};
	int           errors;
	int           check_count;
	int           req_cnt;
	int           rst_cnt;

	cisc_if bus_if ();
	cisc_dev cisc_dev_i (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .bus(bus_if.dev), .eu_irq_in(eu_irq),
		.eu_done_in(eu_done), .eu_busy_in(eu_busy), .eu_req_out(eu_req), .eu_we_out(eu_we), .eu_addr_out(eu_addr),
		.eu_wdata_out(eu_wdata), .eu_rdata_in(eu_rdata), .dest_out(dest), .dev_reset_out(dev_reset));
	cisc_host cisc_host_i (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .bus(bus_if.host), .cmd_valid_in(cmd_valid),
		.cmd_we_in(cmd_we), .cmd_addr_in(cmd_addr), .cmd_wdata_in(cmd_wdata), .cmd_ready_out(cmd_ready),
		.rsp_valid_out(rsp_valid), .rsp_data_out(rsp_data), .start_valid_in(start_valid),
		.start_unit_in(start_unit), .op_active_in(op_active), .irq_out(irq));
	cisc_props cisc_props_i (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .bus_cs_n(bus_if.bus_cs_n),
		.bus_we(bus_if.bus_we), .bus_addr(bus_if.bus_addr), .bus_wdata(bus_if.bus_wdata),
		.bus_rdata(bus_if.bus_rdata), .bus_ack(bus_if.bus_ack), .irq_n(bus_if.irq_n));

	// Free-running 125 MHz clock.
	always #4 ref_clk_in = ~ref_clk_in;

	// Count unit forwards and software reset pulses; both are one-cycle pulses.
	always @(posedge ref_clk_in) begin
		if (eu_req === 1'b1) begin
			req_cnt++;
			fwd_we = eu_we;
			fwd_addr = eu_addr;
			fwd_wdata = eu_wdata;
		end
		if (dev_reset === 1'b1) rst_cnt++;
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk_in);
		#1;
	endtask

	// Waits a bounded time for the host response pulse and keeps its data.
	task automatic wrsp;
		int n;
		n = 0;
		do begin
			tick(1);
			n++;
		end while (rsp_valid !== 1'b1 && n < 20);
		chk("response", 1'b1, rsp_valid);
		rd = rsp_data;
	endtask

	// The request stays up until the edge that finds the port ready.
	task automatic acc(input logic we, input cisc_addr_t a, input cisc_word_t d);
		int n;
		cmd_we = we;
		cmd_addr = a;
		cmd_wdata = d;
		cmd_valid = 1'b1;
		n = 0;
		do begin
			@(negedge ref_clk_in);
			n++;
		end while (cmd_ready !== 1'b1 && n < 20);
		tick(1);
		cmd_valid = 1'b0;
		wrsp();
	endtask

	task automatic rchk(input cisc_addr_t a, input logic [31:0] e, input string s);
		acc(1'b0, a, 32'h0);
		chk(s, e, rd);
	endtask

	task automatic pulse_done(input cisc_eu_vec_t v);
		eu_done = v;
		tick(1);
		eu_done = '0;
		tick(2);
	endtask

	function automatic cisc_word_t cs(input cisc_eu_vec_t rw, input cisc_eu_vec_t mk, input logic [3:0] d,
		input logic [2:0] au);
		cisc_word_t w;
		w = '0;
		w[11:15] = rw & ~mk;
		w[18:22] = rw;
		w[23] = |rw;
		w[24:27] = d;
		w[28:30] = au;
		return w;
	endfunction

	task automatic complete_run;
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// A hang costs far less than this span; the whole sequence needs under three hundred cycles.
	initial begin
		#160000;
		errors++;
		complete_run();
	end

	// Main sequence.
	initial begin
		{errors, check_count, req_cnt, rst_cnt} = '0;
		{rstn_in, cmd_valid, cmd_we, start_valid, op_active, eu_busy} = '0;
		{cmd_addr, cmd_wdata, start_unit, eu_irq, eu_done} = '0;
		eu_rdata = 32'h5a5a_a5a5;
		tick(6);
		rstn_in = 1'b1;
		rchk(IM, 32'h1f, "mask at reset");
		rchk(CS, 32'h0, "status at reset");
		rchk(12'h901, ID_W, "id word");
		acc(1'b1, 12'h901, 32'hffff_ffff);
		rchk(12'h901, ID_W, "id after write");
		rchk(12'h903, 32'h0, "unmapped read");
		// Each unit alone: shown raw while masked, reaches the line once unmasked.
		for (int u = 0; u < 5; u++) begin
			m = 5'h1f;
			r = '0;
			r[u] = 1'b1;
			eu_irq = r;
			tick(2);
			rchk(CS, cs(r, m, 4'h0, 3'h0), "raw status");
			chk("line while masked", 1'b0, irq);
			m[u] = 1'b0;
			acc(1'b1, IM, {27'h0, m});
			tick(2);
			rchk(CS, cs(r, m, 4'h0, 3'h0), "masked status");
			chk("line unmasked", 1'b1, irq);
			eu_irq = '0;
			acc(1'b1, IM, 32'h1f);
		end
		// Two sources at equal priority; the line holds until both are serviced.
		acc(1'b1, IM, 32'h0e);
		eu_irq = 5'b10001;
		tick(3);
		chk("line two pending", 1'b1, irq);
		eu_irq = 5'b00001;
		tick(3);
		chk("line one left", 1'b1, irq);
		eu_irq = '0;
		tick(3);
		chk("line serviced", 1'b0, irq);
		acc(1'b1, IM, 32'h1f);
		foreach (dcodes[i]) begin
			acc(1'b1, CS, cs('0, '0, dcodes[i], 3'h0));
			chk("dest pins", dcodes[i], dest);
			rchk(CS, cs('0, '0, dcodes[i], 3'h0), "dest field");
		end
		// With the auto field off a completion leaves the mask alone.
		acc(1'b1, CS, cs('0, '0, 4'h8, 3'h0));
		pulse_done(5'b10000);
		rchk(IM, 32'h1f, "mask auto off");
		start_unit = 3'h2;
		start_valid = 1'b1;
		tick(1);
		start_valid = 1'b0;
		wrsp();
		rchk(IM, 32'h1f, "mask after start");
		rchk(CS, cs('0, '0, 4'ha, 3'h1), "status after start");
		eu_irq = 5'b00100;
		pulse_done(5'b10000);
		rchk(IM, 32'h1f, "mask other unit done");
		chk("line before done", 1'b0, irq);
		pulse_done(5'b00100);
		rchk(IM, 32'h1b, "mask auto cleared");
		chk("line after done", 1'b1, irq);
		eu_irq = '0;
		// Unit space is closed while busy, registers stay open.
		eu_busy = 1'b1;
		rchk(12'h010, 32'h0, "busy unit read");
		chk("busy forwards", 32'h0, req_cnt);
		rchk(IM, 32'h1b, "register while busy");
		eu_busy = 1'b0;
		rchk(12'h010, 32'h5a5a_a5a5, "idle unit read");
		chk("idle forwards", 32'h1, req_cnt);
		chk("unit read enable", 32'h0, fwd_we);
		acc(1'b1, 12'h020, 32'h1234_5678);
		chk("write forwards", 32'h2, req_cnt);
		chk("unit write enable", 32'h1, fwd_we);
		chk("unit address", 32'h020, fwd_addr);
		chk("unit write data", 32'h1234_5678, fwd_wdata);
		// A running operation holds back status writes and starts; reads still pass.
		op_active = 1'b1;
		cmd_we = 1'b1;
		cmd_addr = CS;
		tick(1);
		chk("ready while active", 1'b0, cmd_ready);
		start_unit = 3'h0;
		start_valid = 1'b1;
		tick(2);
		start_valid = 1'b0;
		rchk(CS, cs('0, 5'h1b, 4'ha, 3'h1), "status while active");
		op_active = 1'b0;
		acc(1'b1, CS, cs('0, '0, 4'h8, 3'h1) | 32'h1);
		tick(2);
		chk("reset pulses", 32'h1, rst_cnt);
		chk("dest after reset", 4'h0, dest);
		rchk(IM, 32'h1f, "mask after reset");
		rchk(CS, 32'h0, "status after reset");
		// A pin reset in mid-run restores the mask just as the software reset does.
		acc(1'b1, IM, 32'h0);
		rstn_in = 1'b0;
		tick(2);
		rstn_in = 1'b1;
		rchk(IM, 32'h1f, "mask after pin reset");
		complete_run();
	end
endmodule
`default_nettype wire
